// file: core/adc_seq_ctrl.sv
// Purpose: sequence, timing and input-select control of a successive-approximation converter
// Assumes: trigger and enable come from logic on REF_CLK_I; analog front end outside
// Notes:   register port answers reads one cycle later; unmapped reads return zero
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "adc_seq_regs.svh"

// How it works
// - The reference field picks supply/ground, external plus, external minus or both, and 1xx acts as 000.
// - Unimplemented bits of the three registers read zero and drop written values.
// - With scan on, the first-setting positive input steps through the inputs set in the scan mask.
// - The half status reads one while the upper half fills and zero while the lower half fills.
// - The sequence event fires after every count-field-plus-one completed sequences.
// - Split mode makes two eight-word halves, otherwise one sixteen-word buffer is filled.
// - With alternation on, the first sample uses the first setting, then second and first take turns.
// - Sampling lasts as many conversion clock periods as the sample-time field says, zero allowed.
// - Bit 12 of the input select picks the second-setting negative input, coded like bit 4.
// - Bits 11 to 8 pick the second-setting positive input, coded like bits 3 to 0.
// - A negative select of one connects analog input 1, zero connects the negative reference.
// - A positive select connects the analog input whose index equals the field.
// - A conversion lasts fourteen conversion clock periods and then writes one result word.
module adc_seq_ctrl
	import adc_seq_pkg::*;
#(
	parameter int CONV_PERIODS = `CONV_PERIODS,
	parameter int DIV_W        = 6
) (
	// clock and reset
	input  wire logic               REF_CLK_I,
	input  wire logic               RESETN_I,
	// register port
	input  wire adc_seq_pkg::reg_addr_t REG_ADDR_I,
	input  wire adc_seq_pkg::reg_data_t REG_WDATA_I,
	input  wire logic               REG_WR_I,
	input  wire logic               REG_RD_I,
	output adc_seq_pkg::reg_data_t  REG_RDATA_O,
	// control from the rest of the converter
	input  wire logic               ENABLE_I,
	input  wire logic               TRIGGER_I,
	input  wire logic [15:0]        SCAN_MASK_I,
	input  wire logic               RC_CLK_I,
	// analog front end steering
	output logic                    HIGH_REF_EXT_O,
	output logic                    LOW_REF_EXT_O,
	output logic [3:0]              POS_INPUT_O,
	output logic                    NEG_INPUT_AN1_O,
	output logic                    SAMPLING_O,
	output logic                    CONVERTING_O,
	// result buffer and event
	output logic                    RESULT_WE_O,
	output logic [3:0]              RESULT_ADDR_O,
	output logic                    SEQ_EVENT_O
);
	initial begin
		if (CONV_PERIODS < 2 || CONV_PERIODS > 63) begin
			$error("adc_seq_ctrl: CONV_PERIODS out of range");
		end
	end

	// next set scan input after cur, wrapping; cur when the mask is empty
	function automatic logic [3:0] next_scan(input logic [15:0] mask, input logic [3:0] cur);
		logic [3:0] idx;
		logic [3:0] res;
		logic       found;
		res   = cur;
		found = 1'b0;
		for (int i = 1; i <= 16; i++) begin
			idx = cur + i[3:0];
			if (!found && mask[idx]) begin
				res   = idx;
				found = 1'b1;
			end
		end
		return res;
	endfunction : next_scan

	// reset release through two flip-flops
	logic rst_meta_r;
	logic rst_n;
	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// register file state
	reg_data_t seq_ctrl_r;
	reg_data_t seq_ctrl_nxt;
	reg_data_t timing_r;
	reg_data_t timing_nxt;
	reg_data_t input_sel_r;
	reg_data_t input_sel_nxt;
	reg_data_t rdata_r;
	reg_data_t rdata_nxt;
	logic      half_r;
	logic      half_nxt;

	// sequencer state
	seq_state_e state_r;
	seq_state_e state_nxt;
	logic [5:0] period_r;
	logic [5:0] period_nxt;
	logic [3:0] seq_cnt_r;
	logic [3:0] seq_cnt_nxt;
	logic [3:0] word_r;
	logic [3:0] word_nxt;
	logic       use_second_r;
	logic       use_second_nxt;
	logic [3:0] scan_idx_r;
	logic [3:0] scan_idx_nxt;

	// registered outputs
	logic       hi_ext_r;
	logic       hi_ext_nxt;
	logic       lo_ext_r;
	logic       lo_ext_nxt;
	logic [3:0] pos_r;
	logic [3:0] pos_nxt;
	logic       neg_r;
	logic       neg_nxt;
	logic       samp_r;
	logic       samp_nxt;
	logic       conv_r;
	logic       conv_nxt;
	logic       we_r;
	logic       we_nxt;
	logic [3:0] addr_r;
	logic [3:0] addr_nxt;
	logic       event_r;
	logic       event_nxt;

	// field views
	logic [2:0] ref_sel;
	logic       scan_en;
	logic [3:0] seq_per_int;
	logic       split_mode;
	logic       alt_mux;
	logic [4:0] sample_time;
	logic       tick;
	logic       seq_done;

	assign ref_sel     = seq_ctrl_r[`REF_SEL_MSB:`REF_SEL_LSB];
	assign scan_en     = seq_ctrl_r[`SCAN_EN_BIT];
	assign seq_per_int = seq_ctrl_r[`SPI_MSB:`SPI_LSB];
	assign split_mode  = seq_ctrl_r[`SPLIT_MODE_BIT];
	assign alt_mux     = seq_ctrl_r[`ALT_MUX_BIT];
	assign sample_time = timing_r[`SAMPLE_TIME_MSB:`SAMPLE_TIME_LSB];
	assign seq_done    = (seq_cnt_r >= seq_per_int); // a lowered count still ends the group

	// conversion clock tick generator
	conv_tick_if #(.DIV_W(DIV_W)) tick_bus ();
	assign tick_bus.use_rc  = timing_r[`CLK_SOURCE_BIT];
	assign tick_bus.divider = timing_r[DIV_W-1:0];
	assign tick             = tick_bus.tick;

	conv_tick_gen #(.DIV_W(DIV_W)) u_tick (
		.clk_i   (REF_CLK_I),
		.rst_n_i (rst_n),
		.rc_clk_i(RC_CLK_I),
		.tick_if (tick_bus)
	);

	// register writes and read data
	always_comb begin
		seq_ctrl_nxt  = seq_ctrl_r;
		timing_nxt    = timing_r;
		input_sel_nxt = input_sel_r;
		rdata_nxt     = '0;
		if (REG_WR_I) begin
			case (REG_ADDR_I)
				`SEQ_CTRL_ADDR: begin
					seq_ctrl_nxt = REG_WDATA_I & `SEQ_CTRL_WMASK;
				end
				`TIMING_CTRL_ADDR: begin
					timing_nxt = REG_WDATA_I & `TIMING_CTRL_WMASK;
				end
				`INPUT_SEL_ADDR: begin
					input_sel_nxt = REG_WDATA_I & `INPUT_SEL_WMASK;
				end
				default: begin
				end
			endcase
		end
		if (REG_RD_I) begin
			case (REG_ADDR_I)
				`SEQ_CTRL_ADDR: begin
					rdata_nxt = seq_ctrl_r;
					rdata_nxt[`HALF_STATUS_BIT] = half_r;
				end
				`TIMING_CTRL_ADDR: begin
					rdata_nxt = timing_r;
				end
				`INPUT_SEL_ADDR: begin
					rdata_nxt = input_sel_r;
				end
				default: begin
					rdata_nxt = '0;
				end
			endcase
		end
	end

	// sequencer: sample, convert, store, buffer bookkeeping
	always_comb begin
		state_nxt      = state_r;
		period_nxt     = period_r;
		seq_cnt_nxt    = seq_cnt_r;
		word_nxt       = word_r;
		use_second_nxt = use_second_r;
		scan_idx_nxt   = scan_idx_r;
		half_nxt       = half_r;
		we_nxt         = 1'b0;
		addr_nxt       = addr_r;
		event_nxt      = 1'b0;
		case (state_r)
			ST_IDLE: begin
				period_nxt = '0;
				if (TRIGGER_I) begin
					state_nxt = (sample_time == 5'h00) ? ST_CONVERT : ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				if (tick) begin
					period_nxt = period_r + 6'h01;
					if (period_r + 6'h01 >= {1'b0, sample_time}) begin
						period_nxt = '0;
						state_nxt  = ST_CONVERT;
					end
				end
			end
			ST_CONVERT: begin
				if (tick) begin
					period_nxt = period_r + 6'h01;
					if (period_r == 6'(CONV_PERIODS - 1)) begin
						period_nxt = '0;
						state_nxt  = ST_STORE;
					end
				end
			end
			ST_STORE: begin
				state_nxt = ST_IDLE;
				we_nxt    = 1'b1;
				if (split_mode) begin
					addr_nxt = {half_r, word_r[2:0]};
				end else begin
					addr_nxt = word_r;
				end
				if (split_mode && word_r[2:0] == 3'h7) begin
					word_nxt = '0;
				end else begin
					word_nxt = word_r + 4'h1;
				end
				if (alt_mux) begin
					use_second_nxt = ~use_second_r;
				end else begin
					use_second_nxt = 1'b0;
				end
				if (scan_en && !use_second_r) begin
					scan_idx_nxt = next_scan(SCAN_MASK_I, scan_idx_r);
				end
				if (seq_done) begin
					seq_cnt_nxt = '0;
					event_nxt   = 1'b1;
					word_nxt    = '0;
					if (split_mode) begin
						half_nxt = ~half_r;
					end
				end else begin
					seq_cnt_nxt = seq_cnt_r + 4'h1;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		if (!ENABLE_I) begin
			state_nxt      = ST_IDLE;
			period_nxt     = '0;
			seq_cnt_nxt    = '0;
			word_nxt       = '0;
			use_second_nxt = 1'b0;
			scan_idx_nxt   = next_scan(SCAN_MASK_I, 4'hF);
			we_nxt         = 1'b0;
			event_nxt      = 1'b0;
		end
		// clearing alternation drops back to the first setting at once
		if (!alt_mux) begin
			use_second_nxt = 1'b0;
		end
	end

	// analog steering from the active multiplexer setting
	always_comb begin
		hi_ext_nxt = ~ref_sel[2] & ref_sel[0];
		lo_ext_nxt = ~ref_sel[2] & ref_sel[1];
		if (use_second_nxt) begin
			pos_nxt = input_sel_nxt[`POS_SECOND_MSB:`POS_SECOND_LSB];
			neg_nxt = input_sel_nxt[`NEG_SECOND_BIT];
		end else begin
			pos_nxt = scan_en ? scan_idx_nxt : input_sel_nxt[`POS_FIRST_MSB:`POS_FIRST_LSB];
			neg_nxt = input_sel_nxt[`NEG_FIRST_BIT];
		end
		samp_nxt = (state_nxt == ST_SAMPLE);
		conv_nxt = (state_nxt == ST_CONVERT);
	end

	// register everything
	always_ff @(posedge REF_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			seq_ctrl_r   <= `SEQ_CTRL_RST;
			timing_r     <= `TIMING_CTRL_RST;
			input_sel_r  <= `INPUT_SEL_RST;
			rdata_r      <= '0;
			half_r       <= 1'b0;
			state_r      <= ST_IDLE;
			period_r     <= '0;
			seq_cnt_r    <= '0;
			word_r       <= '0;
			use_second_r <= 1'b0;
			scan_idx_r   <= '0;
			hi_ext_r     <= 1'b0;
			lo_ext_r     <= 1'b0;
			pos_r        <= '0;
			neg_r        <= 1'b0;
			samp_r       <= 1'b0;
			conv_r       <= 1'b0;
			we_r         <= 1'b0;
			addr_r       <= '0;
			event_r      <= 1'b0;
		end else begin
			seq_ctrl_r   <= seq_ctrl_nxt;
			timing_r     <= timing_nxt;
			input_sel_r  <= input_sel_nxt;
			rdata_r      <= rdata_nxt;
			half_r       <= half_nxt;
			state_r      <= state_nxt;
			period_r     <= period_nxt;
			seq_cnt_r    <= seq_cnt_nxt;
			word_r       <= word_nxt;
			use_second_r <= use_second_nxt;
			scan_idx_r   <= scan_idx_nxt;
			hi_ext_r     <= hi_ext_nxt;
			lo_ext_r     <= lo_ext_nxt;
			pos_r        <= pos_nxt;
			neg_r        <= neg_nxt;
			samp_r       <= samp_nxt;
			conv_r       <= conv_nxt;
			we_r         <= we_nxt;
			addr_r       <= addr_nxt;
			event_r      <= event_nxt;
		end
	end

	// outputs straight from flip-flops
	assign REG_RDATA_O     = rdata_r;
	assign HIGH_REF_EXT_O  = hi_ext_r;
	assign LOW_REF_EXT_O   = lo_ext_r;
	assign POS_INPUT_O     = pos_r;
	assign NEG_INPUT_AN1_O = neg_r;
	assign SAMPLING_O      = samp_r;
	assign CONVERTING_O    = conv_r;
	assign RESULT_WE_O     = we_r;
	assign RESULT_ADDR_O   = addr_r;
	assign SEQ_EVENT_O     = event_r;
endmodule : adc_seq_ctrl

// file: core/adc_seq_pkg.sv
// Purpose: shared types of the converter sequencer
// Assumes: nothing
// Notes:   constants live in adc_seq_regs.svh
package adc_seq_pkg;
	typedef logic [3:0]  reg_addr_t;
	typedef logic [15:0] reg_data_t;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_CONVERT,
		ST_STORE
	} seq_state_e;
endpackage : adc_seq_pkg

// file: core/adc_seq_regs.svh
// Purpose: register offsets, field positions, masks and timing counts of the converter sequencer
// Assumes: 16-bit registers on a word-index register port
// Notes:   included by bare name; definitions only
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// register indices on the plain register port
`define SEQ_CTRL_ADDR      4'h0
`define TIMING_CTRL_ADDR   4'h1
`define INPUT_SEL_ADDR     4'h2

// writable bit masks, unimplemented and reserved bits excluded
`define SEQ_CTRL_WMASK     16'hE43F
`define TIMING_CTRL_WMASK  16'h1FBF
`define INPUT_SEL_WMASK    16'h1F1F

// reset values
`define SEQ_CTRL_RST       16'h0000
`define TIMING_CTRL_RST    16'h0000
`define INPUT_SEL_RST      16'h0000

// sequence control fields
`define REF_SEL_MSB        15
`define REF_SEL_LSB        13
`define SCAN_EN_BIT        10
`define HALF_STATUS_BIT    7
`define SPI_MSB            5
`define SPI_LSB            2
`define SPLIT_MODE_BIT     1
`define ALT_MUX_BIT        0

// timing control fields
`define SAMPLE_TIME_MSB    12
`define SAMPLE_TIME_LSB    8
`define CLK_SOURCE_BIT     7
`define CLK_DIV_MSB        5
`define CLK_DIV_LSB        0

// input select fields
`define NEG_SECOND_BIT     12
`define POS_SECOND_MSB     11
`define POS_SECOND_LSB     8
`define NEG_FIRST_BIT      4
`define POS_FIRST_MSB      3
`define POS_FIRST_LSB      0

// conversion length in conversion clock periods
`define CONV_PERIODS       14
// words per buffer half
`define HALF_WORDS         8

`endif

// file: core/conv_tick_gen.sv
// Purpose: makes one tick per conversion clock period from the reference clock or the rc oscillator
// Assumes: reference clock is twice the instruction rate; rc oscillator is much slower
// Notes:   rc pin passes two flip-flops before the edge detector
`timescale 1ns/1ps
module conv_tick_gen #(
	parameter int DIV_W = 6
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// rc oscillator pin
	input  wire logic rc_clk_i,
	// sequencer side
	conv_tick_if.gen  tick_if
);
	initial begin
		if (DIV_W < 1 || DIV_W > 16) begin
			$error("conv_tick_gen: DIV_W out of range");
		end
	end

	logic [DIV_W-1:0] cnt_r;
	logic [DIV_W-1:0] cnt_nxt;
	logic             rc_meta_r;
	logic             rc_sync_r;
	logic             rc_prev_r;
	logic             tick_r;
	logic             tick_nxt;

	// divide by divider+1 half instruction cycles, or take rc rising edges
	always_comb begin
		cnt_nxt  = cnt_r;
		tick_nxt = 1'b0;
		if (tick_if.use_rc) begin
			cnt_nxt  = '0;
			tick_nxt = rc_sync_r & ~rc_prev_r;
		end else if (cnt_r >= tick_if.divider) begin
			cnt_nxt  = '0;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end

	// register counter, synchroniser and tick
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r     <= '0;
			rc_meta_r <= 1'b0;
			rc_sync_r <= 1'b0;
			rc_prev_r <= 1'b0;
			tick_r    <= 1'b0;
		end else begin
			cnt_r     <= cnt_nxt;
			rc_meta_r <= rc_clk_i;
			rc_sync_r <= rc_meta_r;
			rc_prev_r <= rc_sync_r;
			tick_r    <= tick_nxt;
		end
	end

	assign tick_if.tick = tick_r;
endmodule : conv_tick_gen

// file: core/conv_tick_if.sv
// Purpose: carries clock source choice, divider and tick between sequencer and tick generator
// Assumes: one clock domain
// Notes:   tick is a one-cycle pulse per conversion clock period
`timescale 1ns/1ps
interface conv_tick_if #(parameter int DIV_W = 6);
	logic             use_rc;
	logic [DIV_W-1:0] divider;
	logic             tick;
	modport gen (input use_rc, input divider, output tick);
	modport seq (output use_rc, output divider, input tick);
endinterface : conv_tick_if

// file: test/adc_seq_ctrl_props.sv
// Purpose: port assertions for the converter sequencer
// Assumes: register shadows follow writes made on the register port
// Notes:   bound into adc_seq_ctrl after the module
`timescale 1ns/1ps
`include "adc_seq_regs.svh"
module adc_seq_ctrl_props
	import adc_seq_pkg::*;
#(
	parameter int CONV_PERIODS = 14
) (
	// clock and reset
	input wire logic                   REF_CLK_I,
	input wire logic                   RESETN_I,
	// register port
	input wire adc_seq_pkg::reg_addr_t REG_ADDR_I,
	input wire adc_seq_pkg::reg_data_t REG_WDATA_I,
	input wire logic                   REG_WR_I,
	input wire logic                   REG_RD_I,
	input wire adc_seq_pkg::reg_data_t REG_RDATA_O,
	// sequencer
	input wire logic                   ENABLE_I,
	input wire logic                   TRIGGER_I,
	input wire logic                   HIGH_REF_EXT_O,
	input wire logic                   LOW_REF_EXT_O,
	input wire logic [3:0]             POS_INPUT_O,
	input wire logic                   NEG_INPUT_AN1_O,
	input wire logic                   SAMPLING_O,
	input wire logic                   CONVERTING_O,
	input wire logic                   RESULT_WE_O,
	input wire logic [3:0]             RESULT_ADDR_O,
	input wire logic                   SEQ_EVENT_O
);
	reg_data_t  seq_r, seq_nxt, tim_r, tim_nxt, ins_r, ins_nxt, msk_r, msk_nxt;
	int         conv_r, conv_nxt, idle_r, idle_nxt, per;
	logic       hi_exp, lo_exp, plain, neg1;
	logic [3:0] pos1;

	// shadow registers, read mask and cycle counters
	always_comb begin
		seq_nxt = seq_r;
		tim_nxt = tim_r;
		ins_nxt = ins_r;
		msk_nxt = msk_r;
		if (REG_WR_I && REG_ADDR_I == `SEQ_CTRL_ADDR) seq_nxt = REG_WDATA_I & `SEQ_CTRL_WMASK;
		if (REG_WR_I && REG_ADDR_I == `TIMING_CTRL_ADDR) tim_nxt = REG_WDATA_I & `TIMING_CTRL_WMASK;
		if (REG_WR_I && REG_ADDR_I == `INPUT_SEL_ADDR) ins_nxt = REG_WDATA_I & `INPUT_SEL_WMASK;
		if (REG_RD_I) msk_nxt = (REG_ADDR_I == `SEQ_CTRL_ADDR) ? (`SEQ_CTRL_WMASK | 16'h0080) :
			(REG_ADDR_I == `TIMING_CTRL_ADDR) ? `TIMING_CTRL_WMASK :
			(REG_ADDR_I == `INPUT_SEL_ADDR) ? `INPUT_SEL_WMASK : 16'h0000;
		conv_nxt = CONVERTING_O ? conv_r + 1 : 0;
		idle_nxt = (SAMPLING_O || CONVERTING_O || RESULT_WE_O || !ENABLE_I) ? 0 : ((idle_r < 7) ? idle_r + 1 : idle_r);
	end

	// register the helper state
	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			seq_r  <= 16'h0000;
			tim_r  <= 16'h0000;
			ins_r  <= 16'h0000;
			msk_r  <= 16'h0000;
			conv_r <= 0;
			idle_r <= 0;
		end else begin
			seq_r  <= seq_nxt;
			tim_r  <= tim_nxt;
			ins_r  <= ins_nxt;
			msk_r  <= msk_nxt;
			conv_r <= conv_nxt;
			idle_r <= idle_nxt;
		end
	end

	// expected steering from the shadows
	assign hi_exp = seq_r[15:13] == 3'h1 || seq_r[15:13] == 3'h3;
	assign lo_exp = seq_r[15:13] == 3'h2 || seq_r[15:13] == 3'h3;
	assign plain  = !seq_r[`ALT_MUX_BIT] && !seq_r[`SCAN_EN_BIT];
	assign pos1   = ins_r[3:0];
	assign neg1   = ins_r[4];
	assign per    = int'(tim_r[5:0]) + 1;

	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RESETN_I);

	AST_RD_IDLE_ZERO: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000)
		else $error("read data not zero outside a read");
	AST_RD_UNIMPL_ZERO: assert property ($past(REG_RD_I) |-> (REG_RDATA_O & ~msk_r) == 16'h0000)
		else $error("unimplemented bits read nonzero");
	AST_HIGH_REF: assert property (HIGH_REF_EXT_O == $past(hi_exp))
		else $error("high reference steering wrong");
	AST_LOW_REF: assert property (LOW_REF_EXT_O == $past(lo_exp))
		else $error("low reference steering wrong");
	AST_PLAIN_MUX: assert property (plain && $past(plain) |->
		POS_INPUT_O == pos1 && NEG_INPUT_AN1_O == neg1)
		else $error("first setting not steered");
	AST_START: assert property (idle_r >= 4 && TRIGGER_I && ENABLE_I |=>
		(tim_r[12:8] == 5'h00) ? (CONVERTING_O && !SAMPLING_O) : SAMPLING_O)
		else $error("trigger did not start sequence");
	AST_CONV_LEN: assert property ($fell(CONVERTING_O) && ENABLE_I && $past(ENABLE_I) && !tim_r[7] |->
		conv_r >= (CONV_PERIODS - 1) * per + 1 && conv_r <= CONV_PERIODS * per + 2)
		else $error("conversion length wrong");
	AST_EVENT_WITH_WE: assert property (SEQ_EVENT_O |-> RESULT_WE_O)
		else $error("event without result write");
	AST_WE_PULSE: assert property (RESULT_WE_O |=> !RESULT_WE_O)
		else $error("result write longer than one cycle");

	CVR_EVENT: cover property (SEQ_EVENT_O);
	CVR_TOP_WORD: cover property (RESULT_WE_O && RESULT_ADDR_O == 4'hF);
	CVR_RC_CONV: cover property ($fell(CONVERTING_O) && tim_r[7]);
endmodule : adc_seq_ctrl_props

bind adc_seq_ctrl adc_seq_ctrl_props #(.CONV_PERIODS(CONV_PERIODS)) u_props (
	.REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
	.REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .ENABLE_I(ENABLE_I),
	.TRIGGER_I(TRIGGER_I), .HIGH_REF_EXT_O(HIGH_REF_EXT_O), .LOW_REF_EXT_O(LOW_REF_EXT_O),
	.POS_INPUT_O(POS_INPUT_O), .NEG_INPUT_AN1_O(NEG_INPUT_AN1_O), .SAMPLING_O(SAMPLING_O),
	.CONVERTING_O(CONVERTING_O), .RESULT_WE_O(RESULT_WE_O), .RESULT_ADDR_O(RESULT_ADDR_O),
	.SEQ_EVENT_O(SEQ_EVENT_O));

// file: test/tb_adc_seq_ctrl.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: 100 MHz clock, register port answers one cycle later
// Notes:   rc pin runs at one eighth of the clock
`timescale 1ns/1ps
`include "adc_seq_regs.svh"
module tb_adc_seq_ctrl;
	import adc_seq_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, en = 1'b0, trig = 1'b0, rc = 1'b0;
	reg_addr_t   addr = 4'h0;
	reg_data_t   wdata = 16'h0000;
	logic [15:0] mask = 16'h0092;
	logic [2:0]  rc_cnt = 3'h0;
	reg_data_t   rdata;
	logic        hi_ref, lo_ref, neg, samp, conv, we, ev, s_neg, s_ev;
	logic [3:0]  pos, waddr, s_pos, s_addr;
	int          error_cnt = 0, checks = 0, s_conv, s_samp;

	adc_seq_ctrl u_dut (.REF_CLK_I(clk), .RESETN_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .ENABLE_I(en), .TRIGGER_I(trig),
		.SCAN_MASK_I(mask), .RC_CLK_I(rc), .HIGH_REF_EXT_O(hi_ref), .LOW_REF_EXT_O(lo_ref),
		.POS_INPUT_O(pos), .NEG_INPUT_AN1_O(neg), .SAMPLING_O(samp), .CONVERTING_O(conv),
		.RESULT_WE_O(we), .RESULT_ADDR_O(waddr), .SEQ_EVENT_O(ev));

	// reference clock
	always #5 clk = ~clk;
	// slow rc oscillator pin
	always @(posedge clk) begin
		rc_cnt <= rc_cnt + 3'h1;
		rc     <= rc_cnt[2];
	end

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic reg_wr(input reg_addr_t a, input reg_data_t d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input reg_addr_t a, output reg_data_t d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : reg_rd

	// converter off then on: clears counters and alternation, rewinds scan pointer to the first mask input
	task automatic restart();
		@(posedge clk);
		en <= 1'b0;
		repeat (2) @(posedge clk);
		en <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : restart

	// one triggered sequence; captures steering, word index, event and lengths
	task automatic run_seq();
		int n;
		n = 0;
		@(posedge clk);
		trig <= 1'b1;
		@(posedge clk);
		trig <= 1'b0;
		#1;
		s_pos  = pos;
		s_neg  = neg;
		s_samp = int'(samp === 1'b1);
		s_conv = int'(conv === 1'b1);
		while (we !== 1'b1 && n < 2000) begin
			@(posedge clk);
			#1;
			s_samp += int'(samp === 1'b1);
			s_conv += int'(conv === 1'b1);
			n++;
		end
		s_addr = waddr;
		s_ev   = ev;
		if (n >= 2000) chk("sequence done", 16'h0000, 16'h0001);
		repeat (5) @(posedge clk);
	endtask : run_seq

	task automatic t_regs();
		reg_addr_t ra [4] = '{`SEQ_CTRL_ADDR, `TIMING_CTRL_ADDR, `INPUT_SEL_ADDR, 4'h3};
		reg_data_t rm [4] = '{16'hE43F, 16'h1FBF, 16'h1F1F, 16'h0000};
		reg_data_t d;
		for (int i = 0; i < 4; i++) begin
			reg_rd(ra[i], d);
			chk("reset value", d, 16'h0000);
			reg_wr(ra[i], (i == 0) ? 16'hEFFF : 16'hFFFF); // reserved bit written as zero
			reg_rd(ra[i], d);
			chk("masked readback", d, rm[i]);
			reg_wr(ra[i], 16'h0000);
		end
	endtask : t_regs

	task automatic t_ref();
		for (int v = 0; v < 8; v++) begin
			reg_wr(`SEQ_CTRL_ADDR, {v[2:0], 13'h0000});
			repeat (2) @(posedge clk);
			#1;
			chk("high ref", {15'h0000, hi_ref}, 16'(v[2:0] == 3'h1 || v[2:0] == 3'h3));
			chk("low ref", {15'h0000, lo_ref}, 16'(v[2:0] == 3'h2 || v[2:0] == 3'h3));
		end
	endtask : t_ref

	task automatic t_alt();
		reg_data_t cfg [2] = '{16'h0A15, 16'h1A05};
		for (int c = 0; c < 2; c++) begin
			reg_wr(`INPUT_SEL_ADDR, cfg[c]);
			restart();
			for (int k = 0; k < 3; k++) begin
				run_seq();
				chk("alt pos", {12'h000, s_pos}, 16'((k == 1) ? cfg[c][11:8] : cfg[c][3:0]));
				chk("alt neg", {15'h0000, s_neg}, 16'((k == 1) ? cfg[c][12] : cfg[c][4]));
			end
		end
	endtask : t_alt

	task automatic t_count(input reg_data_t cfg, input int n);
		int        spi;
		int        half;
		reg_data_t d;
		spi  = int'(cfg[5:2]) + 1;
		half = 0;
		reg_wr(`SEQ_CTRL_ADDR, cfg);
		restart();
		for (int k = 0; k < n; k++) begin
			run_seq();
			chk("word index", {12'h000, s_addr}, 16'(half * 8 + k % spi));
			chk("event", {15'h0000, s_ev}, 16'((k % spi) == spi - 1));
			if (cfg[1] && (k % spi) == spi - 1) half = 1 - half;
			reg_rd(`SEQ_CTRL_ADDR, d);
			if (cfg[1]) chk("half status", {15'h0000, d[7]}, 16'(half));
		end
	endtask : t_count

	task automatic t_scan();
		logic [3:0] ep [4] = '{4'h1, 4'h4, 4'h7, 4'h1};
		reg_wr(`SEQ_CTRL_ADDR, 16'h0400);
		restart();
		for (int k = 0; k < 4; k++) begin
			run_seq();
			chk("scan pos", {12'h000, s_pos}, {12'h000, ep[k]});
		end
	endtask : t_scan

	task automatic t_clk();
		reg_wr(`SEQ_CTRL_ADDR, 16'h0000);
		reg_wr(`TIMING_CTRL_ADDR, 16'h1F03);
		run_seq();
		chk("sample len", 16'(s_samp >= 30 * 4 && s_samp <= 31 * 4 + 2), 16'h0001);
		chk("conv len", 16'(s_conv >= 13 * 4 + 1 && s_conv <= 14 * 4 + 2), 16'h0001);
		reg_wr(`TIMING_CTRL_ADDR, 16'h0080);
		run_seq();
		chk("rc conv len", 16'(s_conv >= 13 * 8 && s_conv <= 14 * 8 + 8), 16'h0001);
		chk("zero sample len", 16'(s_samp), 16'h0000);
	endtask : t_clk

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize

	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_ref();
		reg_wr(`TIMING_CTRL_ADDR, 16'h0100);
		reg_wr(`SEQ_CTRL_ADDR, 16'h0001);
		t_alt();
		t_count(16'h0008, 6);
		t_count(16'h003C, 16);
		t_count(16'h0006, 4);
		t_scan();
		t_clk();
		summarize();
	end

	// watchdog against a hang
	initial begin
		#500000;
		error_cnt++;
		summarize();
	end
endmodule : tb_adc_seq_ctrl
